// ---- logic/kpsc_regs.vh ----
`ifndef KPSC_REGS_VH
`define KPSC_REGS_VH

// ----------------------------------------
// Frame and word layout
// ----------------------------------------
`define KPSC_WORD_BITS      8
`define KPSC_CNT_W          4
`define KPSC_FRAME_LEN      4'h8
`define KPSC_ADR2_HI        7
`define KPSC_ADR2_LO        6
`define KPSC_ADR3_LO        5
`define KPSC_ADR_FREQ       2'h0
`define KPSC_ADR_PRESC      2'h1
`define KPSC_ADR_GAIN       2'h2
`define KPSC_ADR3_TC        3'h6
`define KPSC_ADR3_TEST      3'h7

// ----------------------------------------
// Field positions
// ----------------------------------------
`define KPSC_VAL6_HI        5
`define KPSC_VAL5_HI        4
`define KPSC_CHAN_BIT       0
`define KPSC_TEST_HI        4
`define KPSC_TEST_LO        1
`define KPSC_DIV_HI         5
`define KPSC_DIV_LO         1
`define KPSC_HIZ_BIT        0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define KPSC_RST_GAIN       6'h00
`define KPSC_RST_FREQ       6'h00
`define KPSC_RST_TC         5'h00
`define KPSC_RST_CHTEST     5'h00
`define KPSC_RST_DIV        5'h00
`define KPSC_RST_HIZ        1'h1

// ----------------------------------------
// Test selections (test bits of channel word)
// ----------------------------------------
`define KPSC_TSEL_RUN       4'h0
`define KPSC_TSEL_AAF       4'h1
`define KPSC_TSEL_GAIN      4'h2
`define KPSC_TSEL_SCF       4'h3
`define KPSC_TSEL_INTP      4'h4
`define KPSC_TSEL_INTN      4'h5

// ----------------------------------------
// Timing (ns) and clock rate
// ----------------------------------------
`define KPSC_MCLK_MHZ       200
`define KPSC_SYS_KHZ        200
`define KPSC_INT_DLY_NS     20000
`define KPSC_SYS_CNT_W      10
`define KPSC_DLY_CNT_W      13

`endif

// ---- logic/kpsc_sync.v ----
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Three-stage input synchroniser
// ----------------------------------------
module kpsc_sync (
   mclk,
   reset,
   clk_en,
   d_in,
   q_out
);
   input  wire mclk;     // System clock
   input  wire reset;    // Async reset, active high
   input  wire clk_en;   // Freezes state when low
   input  wire d_in;     // Raw pin level
   output wire q_out;    // Filtered level

   reg [2:0] sh_reg;     // Stage 0 feeds only stage 1
   reg       q_reg;      // Accepted level

   assign q_out = q_reg;

   // Shift the pin in; accept a change once stages 1 and 2 agree
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         sh_reg <= 3'h0;
         q_reg  <= 1'h0;
      end else if (clk_en) begin
         sh_reg <= {sh_reg[1:0], d_in};
         if (sh_reg[1] == sh_reg[2]) begin
            q_reg <= sh_reg[2];
         end
      end
   end

endmodule // kpsc_sync

`default_nettype wire

// ---- logic/kpsc_core.v ----
`timescale 1ns/1ps
`default_nettype none
`include "kpsc_regs.vh"

// Function
// [R1] One eight-bit word per chip-select frame
// [R2] Sample serial input on clock falling edge
// [R3] Word assembled most significant bit first
// [R4] Address field then value field
// [R5] Steer word to one of five registers
// [R6] Host may program during hold
// [R7] Host spaces frames by 200 ns
// [R8] Host waits 8 us before integrate
// [R9] Host holds select 80 ns after bit eight
// [R10] Integrate starts, reset within 20 us
// [R11] Hold entered about 20 us after fall
// [R12] Six-bit gain code to both stages
// [R13] Six-bit frequency code to both filters
// [R14] Five-bit integrator time constant code
// [R15] Test mux follows channel/test word
// [R16] Diagnostic mode powers down input amplifiers
// [R17] Antialias evaluation powers down output buffer
// [R18] One input channel routed by channel bit
// [R19] Switched-capacitor stages at 200 kHz
// [R20] Prefix 10 gain, 00 frequency
// [R21] Prefix 110 time constant
// [R22] Prefix 111 channel and test bits
// [R23] Prefix 01 divider and output state
// [R24] Commit only on exact eight-bit frame
module kpsc_core (
   mclk,
   reset,
   clk_en,
   sclk_pin,
   cs_n_pin,
   sdi_pin,
   int_hold_pin,
   gain_code,
   freq_code,
   tc_code,
   channel_select_bit,
   test_sel,
   clock_divider_code,
   so_oe_n,
   in_amp_pd,
   out_buf_pd,
   test_mux_sel,
   integ_run,
   integ_reset,
   sys_tick
);
   input  wire       mclk;               // 200 MHz clock
   input  wire       reset;              // Async reset, active high
   input  wire       clk_en;             // Freezes all state when low
   input  wire       sclk_pin;           // Serial clock pin
   input  wire       cs_n_pin;           // Chip select pin, active low
   input  wire       sdi_pin;            // Serial data in pin
   input  wire       int_hold_pin;       // Integrate high, hold low
   output wire [5:0] gain_code;          // Gain code to both gain stages
   output wire [5:0] freq_code;          // Centre frequency to both filters
   output wire [4:0] tc_code;            // Integrator time constant
   output wire       channel_select_bit; // 0 selects input 0, 1 input 1
   output wire [3:0] test_sel;           // Diagnostic selection bits
   output wire [4:0] clock_divider_code; // Prescaler code
   output wire       so_oe_n;            // Serial out enable, low drives
   output wire       in_amp_pd;          // Input amplifiers powered down
   output wire       out_buf_pd;         // Output buffer powered down
   output wire [3:0] test_mux_sel;       // Test mux source
   output wire       integ_run;          // Integrator integrating
   output wire       integ_reset;        // Integrator forced to reset level
   output wire       sys_tick;           // 200 kHz switched-cap strobe

   // ----------------------------------------
   // Derived timing counts
   // ----------------------------------------
   // Cycles per system tick, exact at these rates
   localparam [31:0] SYS_DIV = (`KPSC_MCLK_MHZ * 1000) / `KPSC_SYS_KHZ;
   // Longest time, so rounded down
   localparam [31:0] DLY_CYC = (`KPSC_INT_DLY_NS * `KPSC_MCLK_MHZ) / 1000;
   localparam [`KPSC_SYS_CNT_W-1:0] SYS_LAST = SYS_DIV[`KPSC_SYS_CNT_W-1:0] - 1'h1;
   localparam [`KPSC_DLY_CNT_W-1:0] DLY_LAST = DLY_CYC[`KPSC_DLY_CNT_W-1:0] - 1'h1;

   // Integrator states
   localparam [1:0] ST_HOLD  = 2'h0;
   localparam [1:0] ST_RST   = 2'h1;
   localparam [1:0] ST_INT   = 2'h2;
   localparam [1:0] ST_TOHLD = 2'h3;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   wire sclk_s;  // Clean serial clock
   wire cs_n_s;  // Clean chip select
   wire sdi_s;   // Clean data
   wire ih_s;    // Clean integrate/hold

   wire [3:0] pin_raw;  // Raw pins
   wire [3:0] pin_clean; // Filtered pins
   assign pin_raw = {int_hold_pin, sdi_pin, cs_n_pin, sclk_pin};
   assign sclk_s  = pin_clean[0];
   assign cs_n_s  = pin_clean[1];
   assign sdi_s   = pin_clean[2];
   assign ih_s    = pin_clean[3];

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
         kpsc_sync u_sync (
            .mclk  (mclk),
            .reset (reset),
            .clk_en(clk_en),
            .d_in  (pin_raw[gi]),
            .q_out (pin_clean[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Serial receiver
   // ----------------------------------------
   reg                   sclk_d_reg;  // Previous serial clock
   reg                   cs_d_reg;    // Previous chip select
   reg [7:0]             shift_reg;   // Incoming word
   reg [`KPSC_CNT_W-1:0] cnt_reg;     // Falling edges this frame
   reg                   ovf_reg;     // More than eight edges seen

   wire sclk_fall;  // Sampling edge
   wire cs_rise;    // Frame end
   wire commit;     // Valid eight-bit frame ended
   assign sclk_fall = sclk_d_reg & ~sclk_s & ~cs_n_s;
   assign cs_rise   = cs_n_s & ~cs_d_reg;
   // [R24] exact length commit
   assign commit    = cs_rise & (cnt_reg == `KPSC_FRAME_LEN) & ~ovf_reg;

   // Shift on falling edges while selected; clear count while deselected
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         sclk_d_reg <= 1'h0;
         cs_d_reg   <= 1'h1;
         shift_reg  <= 8'h00;
         cnt_reg    <= 4'h0;
         ovf_reg    <= 1'h0;
      end else if (clk_en) begin
         sclk_d_reg <= sclk_s;
         cs_d_reg   <= cs_n_s;
         if (cs_n_s) begin
            // Idle: ready for a fresh frame
            cnt_reg <= 4'h0;
            ovf_reg <= 1'h0;
         end else if (sclk_fall) begin
            // [R2] sample on fall
            // [R3] MSB arrives first
            shift_reg <= {shift_reg[6:0], sdi_s};
            // [R1] count eight bits
            if (cnt_reg == `KPSC_FRAME_LEN) begin
               ovf_reg <= 1'h1;
            end else begin
               cnt_reg <= cnt_reg + 4'h1;
            end
         end
      end
   end

   // ----------------------------------------
   // Setting registers
   // ----------------------------------------
   reg [5:0] gain_reg;   // Gain code
   reg [5:0] freq_reg;   // Frequency code
   reg [4:0] tc_reg;     // Time constant code
   reg [4:0] chtest_reg; // Channel and test bits
   reg [4:0] div_reg;    // Prescaler code
   reg       hiz_reg;    // Serial output high impedance

   wire [1:0] adr2;  // Two-bit address
   wire [2:0] adr3;  // Three-bit address
   assign adr2 = shift_reg[`KPSC_ADR2_HI:`KPSC_ADR2_LO];
   assign adr3 = shift_reg[`KPSC_ADR2_HI:`KPSC_ADR3_LO];

   // Decode on commit; written at any time, hold is only the usual case
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         gain_reg   <= `KPSC_RST_GAIN;
         freq_reg   <= `KPSC_RST_FREQ;
         tc_reg     <= `KPSC_RST_TC;
         chtest_reg <= `KPSC_RST_CHTEST;
         div_reg    <= `KPSC_RST_DIV;
         hiz_reg    <= `KPSC_RST_HIZ;
      end else if (clk_en && commit) begin
         // [R4] address then value
         // [R5] five target registers
         case (adr2)
            `KPSC_ADR_FREQ: begin
               // [R13] frequency code
               // [R20] prefix 00
               freq_reg <= shift_reg[`KPSC_VAL6_HI:0];
            end
            `KPSC_ADR_GAIN: begin
               // [R12] gain code
               // [R20] prefix 10
               gain_reg <= shift_reg[`KPSC_VAL6_HI:0];
            end
            `KPSC_ADR_PRESC: begin
               // [R23] divider and Z bit
               div_reg <= shift_reg[`KPSC_DIV_HI:`KPSC_DIV_LO];
               hiz_reg <= shift_reg[`KPSC_HIZ_BIT];
            end
            default: begin
               // [R21] prefix 110
               // [R14] time constant code
               if (adr3 == `KPSC_ADR3_TC) begin
                  tc_reg <= shift_reg[`KPSC_VAL5_HI:0];
               end else begin
                  // [R22] prefix 111
                  chtest_reg <= shift_reg[`KPSC_VAL5_HI:0];
               end
            end
         endcase
      end
   end

   // ----------------------------------------
   // Setting outputs and diagnostics
   // ----------------------------------------
   assign gain_code          = gain_reg;
   assign freq_code          = freq_reg;
   assign tc_code            = tc_reg;
   // [R18] channel select switch
   assign channel_select_bit = chtest_reg[`KPSC_CHAN_BIT];
   assign test_sel           = chtest_reg[`KPSC_TEST_HI:`KPSC_TEST_LO];
   assign clock_divider_code = div_reg;
   assign so_oe_n            = hiz_reg;
   // [R15] mux follows test bits
   assign test_mux_sel       = test_sel;
   // [R16] diagnostic amplifier power-down
   assign in_amp_pd          = (test_sel != `KPSC_TSEL_RUN);
   // [R17] buffer off for antialias
   assign out_buf_pd         = (test_sel == `KPSC_TSEL_AAF);

   // ----------------------------------------
   // System rate strobe
   // ----------------------------------------
   reg [`KPSC_SYS_CNT_W-1:0] sys_cnt_reg;  // Divider count
   reg                       tick_reg;     // One-cycle strobe

   // [R19] 200 kHz strobe
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         sys_cnt_reg <= 10'h000;
         tick_reg    <= 1'h0;
      end else if (clk_en) begin
         tick_reg <= (sys_cnt_reg == SYS_LAST);
         if (sys_cnt_reg == SYS_LAST) begin
            sys_cnt_reg <= 10'h000;
         end else begin
            sys_cnt_reg <= sys_cnt_reg + 10'h001;
         end
      end
   end
   assign sys_tick = tick_reg;

   // ----------------------------------------
   // Integrate/hold sequencer
   // ----------------------------------------
   reg [1:0]                 st_reg;   // Sequencer state
   reg [1:0]                 st_next;  // Next state
   reg [`KPSC_DLY_CNT_W-1:0] dly_reg;  // Delay counter
   reg                       ih_d_reg; // Previous integrate level

   wire ih_rise;  // Integrate request
   wire ih_fall;  // Hold request
   wire dly_done; // Delay expired
   assign ih_rise  = ih_s & ~ih_d_reg;
   assign ih_fall  = ~ih_s & ih_d_reg;
   assign dly_done = (dly_reg == DLY_LAST);

   // Next state; an edge restarts the matching phase at once
   always @* begin
      st_next = st_reg;
      case (st_reg)
         ST_HOLD: begin
            if (ih_rise) begin
               st_next = ST_RST;
            end
         end
         ST_RST: begin
            // [R10] reset within 20 us
            if (ih_fall) begin
               st_next = ST_TOHLD;
            end else if (dly_done) begin
               st_next = ST_INT;
            end
         end
         ST_INT: begin
            if (ih_fall) begin
               st_next = ST_TOHLD;
            end
         end
         ST_TOHLD: begin
            // [R11] hold after delay
            if (ih_rise) begin
               st_next = ST_RST;
            end else if (dly_done) begin
               st_next = ST_HOLD;
            end
         end
         default: begin
            st_next = ST_HOLD;
         end
      endcase
   end

   // State and delay counter; counter restarts on every state change
   always @(posedge mclk or posedge reset) begin
      if (reset) begin
         st_reg   <= ST_HOLD;
         dly_reg  <= 13'h0000;
         ih_d_reg <= 1'h0;
      end else if (clk_en) begin
         ih_d_reg <= ih_s;
         st_reg   <= st_next;
         if (st_next != st_reg) begin
            dly_reg <= 13'h0000;
         end else if (!dly_done) begin
            dly_reg <= dly_reg + 13'h0001;
         end
      end
   end

   // Integrator keeps running during the hold delay, frozen after
   assign integ_reset = (st_reg == ST_RST);
   assign integ_run   = (st_reg == ST_INT) | (st_reg == ST_TOHLD);

endmodule // kpsc_core

`default_nettype wire

// ---- tb/kpsc_host.sv ----
`timescale 1ns/1ps
`default_nettype none

// ------------
// Host model of the serial programming port
// ------------
module kpsc_host (
   input  wire logic mclk,
   output var  logic sclk_pin,
   output var  logic cs_n_pin,
   output var  logic sdi_pin
);
   int half = 12; // Clock phase in mclk cycles; 12 is the 60 ns minimum

   // Serial clock stands still low between frames
   initial begin
      sclk_pin = 1'b0;
      cs_n_pin = 1'b1;
      sdi_pin  = 1'b0;
   end

   // Moves only on falling mclk, like the bench
   task automatic wt(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic send(input logic [8:0] d, input int n);
      cs_n_pin = 1'b0;
      wt(16);
      for (int i = n - 1; i >= 0; i--) begin
         sdi_pin = d[i];
         wt(half);
         sclk_pin = 1'b1;
         wt(half);
         sclk_pin = 1'b0;
         wt(2);
      end
      wt(14);
      cs_n_pin = 1'b1;
      // Released data shows the inverse, so a stale bit never looks valid
      sdi_pin = ~sdi_pin;
      wt(40);
   endtask
endmodule // kpsc_host

`default_nettype wire

// ---- tb/kpsc_core_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none

module kpsc_core_asserts (
   input wire logic       mclk,
   input wire logic       reset,
   input wire logic       clk_en,
   input wire logic       cs_n_pin,
   input wire logic       int_hold_pin,
   input wire logic [5:0] gain_code,
   input wire logic [5:0] freq_code,
   input wire logic [4:0] tc_code,
   input wire logic       channel_select_bit,
   input wire logic [3:0] test_sel,
   input wire logic [4:0] clock_divider_code,
   input wire logic       so_oe_n,
   input wire logic       in_amp_pd,
   input wire logic       out_buf_pd,
   input wire logic [3:0] test_mux_sel,
   input wire logic       integ_run,
   input wire logic       integ_reset,
   input wire logic       sys_tick
);
   // ------------
   // Helper counters
   // ------------
   logic [15:0] rst_cnt_reg;  // Cycles spent in integrator reset
   logic [15:0] hold_cnt_reg; // Cycles since integrate input fell
   logic [9:0]  gap_cnt_reg;  // Cycles since last system strobe
   logic        seen_reg;     // First strobe has no known gap
   logic [27:0] set_v;        // All settings outputs together

   assign set_v = {gain_code, freq_code, tc_code, test_sel, channel_select_bit,
                   clock_divider_code, so_oe_n};

   // Counters clear on reset and count only enabled cycles, like the design
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         rst_cnt_reg  <= 16'h0000;
         hold_cnt_reg <= 16'h0000;
         gap_cnt_reg  <= 10'h000;
         seen_reg     <= 1'b0;
      end else if (clk_en) begin
         rst_cnt_reg  <= integ_reset ? rst_cnt_reg + 16'h0001 : 16'h0000;
         hold_cnt_reg <= int_hold_pin ? 16'h0000 : hold_cnt_reg + 16'h0001;
         gap_cnt_reg  <= sys_tick ? 10'h000 : gap_cnt_reg + 10'h001;
         seen_reg     <= seen_reg | sys_tick;
      end
   end

   // ------------
   // Properties
   // ------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset || !clk_en);

   sequence s_rst_soon;
      ##[1:8] integ_reset;
   endsequence
   sequence s_rst_end;
      integ_reset ##1 (!integ_reset && integ_run);
   endsequence
   sequence s_run_end;
      integ_run ##1 !integ_run;
   endsequence

   a_state_excl:
      assert property (!(integ_run && integ_reset)) else $error("run and reset together");
   a_reset_entry:
      assert property ($rose(int_hold_pin) |-> s_rst_soon) else $error("reset phase late");
   a_reset_len:
      assert property (s_rst_end |-> rst_cnt_reg == 16'h0FA0 || hold_cnt_reg != 16'h0000)
         else $error("reset phase length wrong");
   a_hold_len:
      assert property (s_run_end |-> integ_reset ||
                       (hold_cnt_reg >= 16'h0FA0 && hold_cnt_reg <= 16'h0FAC))
         else $error("hold delay wrong");
   a_run_entry:
      assert property ($rose(integ_run) |-> $past(integ_reset)) else $error("run without reset");
   a_commit_gap:
      assert property ($changed(set_v) |-> $past(cs_n_pin, 3)) else $error("commit inside frame");
   a_mux_follow:
      assert property (test_mux_sel == test_sel) else $error("test mux mismatch");
   a_inamp_down:
      assert property (in_amp_pd == (test_sel != 4'h0)) else $error("input amp state wrong");
   a_outbuf_down:
      assert property (out_buf_pd == (test_sel == 4'h1)) else $error("output buffer state wrong");
   a_tick_gap:
      assert property (sys_tick && seen_reg |-> gap_cnt_reg == 10'h3E7) else $error("strobe gap");
endmodule // kpsc_core_asserts

`default_nettype wire

// ---- tb/tb_kpsc_core.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_kpsc_core;
   // ------------
   // Signals
   // ------------
   typedef struct packed {
      logic [7:0] w;   // Programming word
      logic [2:0] sel; // Field it loads
      logic [5:0] val; // Value expected there
   } kpsc_row_t;
   logic        mclk;
   logic        reset;
   logic        clk_en;
   logic        int_hold_pin;
   logic        sclk_pin, cs_n_pin, sdi_pin;
   logic [5:0]  gain_code, freq_code;
   logic [4:0]  tc_code, clock_divider_code;
   logic [3:0]  test_sel, test_mux_sel;
   logic        channel_select_bit, so_oe_n, in_amp_pd, out_buf_pd;
   logic        integ_run, integ_reset, sys_tick;
   logic [27:0] ev;            // Expected settings, packed like the checker
   int          failures = 0;
   int          compares = 0;
   int          cycles = 0;    // Hang guard
   // Every address prefix and every test code
   kpsc_row_t   rows [16] = '{'{8'h0A, 3'h0, 6'h0A}, '{8'h3F, 3'h0, 6'h3F},
      '{8'h94, 3'h2, 6'h14}, '{8'hBF, 3'h2, 6'h3F}, '{8'hC3, 3'h3, 6'h03},
      '{8'hDF, 3'h3, 6'h1F}, '{8'h40, 3'h1, 6'h00}, '{8'h7F, 3'h1, 6'h3F},
      '{8'hE1, 3'h4, 6'h01}, '{8'hE3, 3'h4, 6'h03}, '{8'hE4, 3'h4, 6'h04},
      '{8'hE6, 3'h4, 6'h06}, '{8'hE8, 3'h4, 6'h08}, '{8'hEA, 3'h4, 6'h0A},
      '{8'hFE, 3'h4, 6'h1E}, '{8'hE0, 3'h4, 6'h00}};

   kpsc_host i_kpsc_host (.mclk, .sclk_pin, .cs_n_pin, .sdi_pin);
   kpsc_core i_kpsc_core (.mclk, .reset, .clk_en, .sclk_pin, .cs_n_pin, .sdi_pin,
      .int_hold_pin, .gain_code, .freq_code, .tc_code, .channel_select_bit,
      .test_sel, .clock_divider_code, .so_oe_n, .in_amp_pd, .out_buf_pd,
      .test_mux_sel, .integ_run, .integ_reset, .sys_tick);

   // ------------
   // Tasks
   // ------------
   task automatic wt(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Settings plus the test path flags derived from them
   task automatic chk_set();
      chk("settings", {4'h0, ev}, {4'h0, gain_code, freq_code, tc_code, test_sel,
          channel_select_bit, clock_divider_code, so_oe_n});
      chk("test path", {26'h0, ev[10:7], ev[10:7] != 4'h0, ev[10:7] == 4'h1},
          {26'h0, test_mux_sel, in_amp_pd, out_buf_pd});
   endtask

   // Moves one field of the expected settings
   task automatic put(input logic [2:0] sel, input logic [5:0] val);
      case (sel)
         3'h0:    ev[21:16] = val;
         3'h1:    ev[5:0] = val;
         3'h2:    ev[27:22] = val;
         3'h3:    ev[15:11] = val[4:0];
         default: ev[10:6] = val[4:0];
      endcase
   endtask

   // Eight cycles of reset; outputs idle inside it and defaults after
   task automatic do_reset();
      reset = 1'b1;
      wt(4);
      chk("idle in reset", 32'h0, {29'h0, integ_run, integ_reset, sys_tick});
      wt(4);
      reset = 1'b0;
      ev = 28'h0000001;
      wt(6);
      chk_set();
   endtask

   task automatic test_done();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ------------
   // Clock, guard and sequence
   // ------------
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // Whole run needs about 16000 cycles
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         failures++;
         test_done();
      end
   end

   initial begin
      int n;
      reset = 1'b1;
      clk_en = 1'b1;
      int_hold_pin = 1'b0;
      do_reset();
      $display("test reset done");
      foreach (rows[k]) begin
         i_kpsc_host.send({1'b0, rows[k].w}, 8);
         wt(12);
         put(rows[k].sel, rows[k].val);
         chk_set();
      end
      $display("test word table done");
      i_kpsc_host.send(9'h055, 7);
      i_kpsc_host.send(9'h1FF, 9);
      wt(12);
      chk_set();
      $display("test frame length done");
      i_kpsc_host.half = 40;
      i_kpsc_host.send(9'h081, 8);
      i_kpsc_host.half = 12;
      wt(12);
      put(3'h2, 6'h01);
      chk_set();
      $display("test slow host done");
      // Enable low: a whole frame must leave every setting untouched
      clk_en = 1'b0;
      i_kpsc_host.send(9'h08F, 8);
      clk_en = 1'b1;
      wt(12);
      chk_set();
      $display("test clock enable done");
      wt(1600);
      int_hold_pin = 1'b1;
      n = 0;
      while (integ_reset !== 1'b1 && n < 4000) begin
         wt(1);
         n++;
      end
      chk("reset entry", 32'h1, {31'h0, n < 4000});
      n = 0;
      while (integ_reset === 1'b1 && n < 5000) begin
         wt(1);
         n++;
      end
      chk("reset length", 32'h00000FA0, n);
      chk("integrating", 32'h1, {31'h0, integ_run});
      int_hold_pin = 1'b0;
      n = 0;
      while (integ_run === 1'b1 && n < 5000) begin
         wt(1);
         n++;
      end
      chk("hold delay", 32'h1, {31'h0, n >= 4000 && n <= 4012});
      $display("test integrate done");
      do_reset();
      $display("test second reset done");
      test_done();
   end
endmodule // tb_kpsc_core

bind kpsc_core kpsc_core_asserts i_kpsc_core_asserts (.mclk, .reset, .clk_en, .cs_n_pin,
   .int_hold_pin, .gain_code, .freq_code, .tc_code, .channel_select_bit, .test_sel,
   .clock_divider_code, .so_oe_n, .in_amp_pd, .out_buf_pd, .test_mux_sel,
   .integ_run, .integ_reset, .sys_tick);

`default_nettype wire
